// file: pci_host_agent.sv
// Purpose: Far-end agent that initiates transfers toward the device.
// Assumes: Same clock as the device; it owns the bus only when told to.
// Notes: A corrupt request flips the parity it sends for test use.
`timescale 1ns/100ps
`default_nettype none

module pci_host_agent
  import pci_sig_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  pci_link_if.host link,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic [AD_W-1:0] reqAddr,
  input wire logic [CBE_W-1:0] reqCmd,
  input wire logic [AD_W-1:0] reqData,
  input wire logic [CBE_W-1:0] reqBeN,
  input wire logic reqCorrupt,
  output logic rxAddrValid,
  output logic [AD_W-1:0] rxAddr,
  output logic rxDataValid,
  output logic [AD_W-1:0] rxData,
  output logic perrSeen
);

  // ==========================================================
  // Initiator.
  phase_t phase_reg;
  logic [AD_W-1:0] dataHold_reg;
  logic [CBE_W-1:0] beHold_reg;
  logic corrupt_reg;
  logic [AD_W-1:0] adOut_reg;
  logic [CBE_W-1:0] cbeOut_reg;
  logic busOe_reg;
  logic parOut_reg;
  logic parOe_reg;
  logic addrPhase_reg;
  logic dataPhase_reg;
  logic accept;

  assign reqReady = (phase_reg == PH_IDLE) & ~reset;
  assign accept = reqValid & reqReady;

  always_ff @(posedge clk) begin
    if (reset) begin
      phase_reg <= PH_IDLE;
    end else begin
      unique case (phase_reg)
        PH_IDLE: begin
          if (accept) begin
            phase_reg <= PH_ADDR;
          end
        end
        PH_ADDR: begin
          phase_reg <= PH_DATA;
        end
        PH_DATA: begin
          phase_reg <= PH_PAR;
        end
        PH_PAR: begin
          phase_reg <= PH_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      adOut_reg <= AD_RST;
      cbeOut_reg <= CBE_RST;
      busOe_reg <= 1'b0;
      addrPhase_reg <= 1'b0;
      dataPhase_reg <= 1'b0;
      dataHold_reg <= AD_RST;
      beHold_reg <= CBE_RST;
      corrupt_reg <= 1'b0;
    end else begin
      addrPhase_reg <= accept;
      dataPhase_reg <= (phase_reg == PH_ADDR);
      if (accept) begin
        adOut_reg <= reqAddr;
        cbeOut_reg <= reqCmd;
        busOe_reg <= 1'b1;
        dataHold_reg <= reqData;
        beHold_reg <= reqBeN;
        corrupt_reg <= reqCorrupt;
      end else if (phase_reg == PH_ADDR) begin
        adOut_reg <= dataHold_reg;
        cbeOut_reg <= beHold_reg;
      end else if (phase_reg == PH_DATA) begin
        busOe_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      parOut_reg <= PAR_RST;
      parOe_reg <= 1'b0;
    end else begin
      parOe_reg <= busOe_reg;
      parOut_reg <= evenPar(adOut_reg, cbeOut_reg) ^ corrupt_reg;
    end
  end

  assign link.hostAdOut = adOut_reg;
  assign link.hostCbeOut = cbeOut_reg;
  assign link.hostParOut = parOut_reg;
  assign link.hostAdOe = busOe_reg;
  assign link.hostCbeOe = busOe_reg;
  assign link.hostParOe = parOe_reg;
  assign link.hostAddrPhase = addrPhase_reg;
  assign link.hostDataPhase = dataPhase_reg;

  // ==========================================================
  // Observer of device-driven phases and the error line.
  always_ff @(posedge clk) begin
    if (reset) begin
      rxAddrValid <= 1'b0;
      rxDataValid <= 1'b0;
      rxAddr <= AD_RST;
      rxData <= AD_RST;
      perrSeen <= 1'b0;
    end else begin
      rxAddrValid <= link.addrPhase & ~busOe_reg;
      rxDataValid <= link.dataPhase & ~busOe_reg;
      if (link.addrPhase && !busOe_reg) begin
        rxAddr <= link.ad;
      end
      if (link.dataPhase && !busOe_reg) begin
        rxData <= link.ad & laneMask(link.cbeN);
      end
      perrSeen <= ~link.perrN;
    end
  end

endmodule : pci_host_agent

`default_nettype wire

// file: pci_link_if.sv
// Purpose: Shared bus between the device end and the far agent.
// Assumes: Both ends run on the same clock; no end drives when disabled.
// Notes: Resolves AD, C/BE, PAR and PERR from the enables, idle ones reading as pulled up; phase lines OR both ends.
`timescale 1ns/100ps
`default_nettype none

interface pci_link_if;
  import pci_sig_pkg::*;

  // ==========================================================
  // Driver side of each end.
  logic [AD_W-1:0] devAdOut;
  logic devAdOe;
  logic [CBE_W-1:0] devCbeOut;
  logic devCbeOe;
  logic devParOut;
  logic devParOe;
  logic devPerrOutN;
  logic devPerrOe;
  logic devAddrPhase;
  logic devDataPhase;
  logic [AD_W-1:0] hostAdOut;
  logic hostAdOe;
  logic [CBE_W-1:0] hostCbeOut;
  logic hostCbeOe;
  logic hostParOut;
  logic hostParOe;
  logic hostAddrPhase;
  logic hostDataPhase;

  // ==========================================================
  // Resolved wire levels.
  logic [AD_W-1:0] ad;
  logic [CBE_W-1:0] cbeN;
  logic par;
  logic perrN;
  logic addrPhase;
  logic dataPhase;

  assign ad = devAdOe ? devAdOut : (hostAdOe ? hostAdOut : '1);
  assign cbeN = devCbeOe ? devCbeOut : (hostCbeOe ? hostCbeOut : '1);
  assign par = devParOe ? devParOut : (hostParOe ? hostParOut : 1'b1);
  assign perrN = devPerrOe ? devPerrOutN : 1'b1;
  assign addrPhase = devAddrPhase | hostAddrPhase;
  assign dataPhase = devDataPhase | hostDataPhase;

  modport dev (
    output devAdOut, devAdOe, devCbeOut, devCbeOe, devParOut, devParOe,
    output devPerrOutN, devPerrOe, devAddrPhase, devDataPhase,
    input ad, cbeN, par, perrN, addrPhase, dataPhase
  );

  modport host (
    output hostAdOut, hostAdOe, hostCbeOut, hostCbeOe, hostParOut,
    output hostParOe, hostAddrPhase, hostDataPhase,
    input ad, cbeN, par, perrN, addrPhase, dataPhase
  );

endinterface : pci_link_if

`default_nettype wire

// file: pci_link_monitor.sv
// Purpose: Checks wire timing between the two bus ends.
// Assumes: One clock; reset synchronous and active high.
// Notes: Watches the shared interface signals only.
`timescale 1ns/100ps
`default_nettype none

module pci_link_monitor
  import pci_sig_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic devAdOe,
  input wire logic devCbeOe,
  input wire logic devParOe,
  input wire logic devPerrOe,
  input wire logic devAddrPhase,
  input wire logic devDataPhase,
  input wire logic hostAddrPhase,
  input wire logic hostDataPhase,
  input wire logic [AD_W-1:0] ad,
  input wire logic [CBE_W-1:0] cbeN,
  input wire logic par,
  input wire logic perrN
);
  // ==========================================================
  // Properties.
  default clocking cb @(posedge clk); endclocking

  property p_rstFloat;
    reset |-> !(devAdOe || devCbeOe || devParOe || devPerrOe);
  endproperty
  property p_addrDrive;
    disable iff (reset) devAddrPhase |-> devAdOe && devCbeOe;
  endproperty
  property p_addrThenData;
    disable iff (reset) devAddrPhase |=> devDataPhase && devAdOe;
  endproperty
  property p_dataOne;
    disable iff (reset) devDataPhase |=> !devDataPhase && !devAdOe;
  endproperty
  property p_parity;
    disable iff (reset) (devAddrPhase || devDataPhase) |=>
      devParOe && par == ^{$past(ad), $past(cbeN)};
  endproperty
  property p_parEnd;
    disable iff (reset) (devParOe && !devAdOe) |=> !devParOe;
  endproperty
  property p_perrBad;
    disable iff (reset) (hostAddrPhase || hostDataPhase) ##1
      (par != ^{$past(ad), $past(cbeN)}) |=> !perrN;
  endproperty
  property p_perrGood;
    disable iff (reset) (hostAddrPhase || hostDataPhase) ##1
      (par == ^{$past(ad), $past(cbeN)}) |=> perrN;
  endproperty
  property p_hostOrder;
    disable iff (reset) hostAddrPhase |=> hostDataPhase ##1 !hostDataPhase;
  endproperty

  a_rstFloat: assert property (p_rstFloat)
    else $error("driver on in reset");
  a_addrDrive: assert property (p_addrDrive)
    else $error("address undriven");
  a_addrThenData: assert property (p_addrThenData)
    else $error("no data");
  a_dataOne: assert property (p_dataOne)
    else $error("data too long");
  a_parity: assert property (p_parity)
    else $error("bad parity out");
  a_parEnd: assert property (p_parEnd)
    else $error("parity too long");
  a_perrBad: assert property (p_perrBad)
    else $error("missed error");
  a_perrGood: assert property (p_perrGood)
    else $error("false error");
  a_hostOrder: assert property (p_hostOrder)
    else $error("host order");

  c_devXfer: cover property (devAddrPhase ##1 devDataPhase);
  c_hostXfer: cover property (hostAddrPhase ##1 hostDataPhase);
  c_perr: cover property (!perrN);
endmodule : pci_link_monitor

`default_nettype wire

// file: pci_primary_signal_core.sv
// Purpose: Device end of the primary bus signalling core.
// Assumes: Bus ownership is settled outside; one data phase per transfer.
// Notes: Suspend during reset keeps phase, hold and capture state while all drivers float; valid and error flags still clear.
// Behaviour
// - Sample every bus signal on rising clock.
// - Reset without suspend floats outputs, clears state.
// - After reset release, start in default state.
// - Reset with suspend floats outputs, keeps state.
// - Address phase carries address on AD.
// - Data phases carry data on AD.
// - C/BE carries command, then byte enables.
// - Byte enable n governs AD byte n.
// - Compute even parity over AD and C/BE.
// - As initiator, drive parity one clock later.
// - As target, flag parity mismatch on error line.
`timescale 1ns/100ps
`default_nettype none

module pci_primary_signal_core
  import pci_sig_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic suspend,
  pci_link_if.dev link,
  input wire logic initValid,
  output logic initReady,
  input wire logic [AD_W-1:0] initAddr,
  input wire logic [CBE_W-1:0] initCmd,
  input wire logic [AD_W-1:0] initData,
  input wire logic [CBE_W-1:0] initBeN,
  output logic tgtAddrValid,
  output logic [AD_W-1:0] tgtAddr,
  output logic [CBE_W-1:0] tgtCmd,
  output logic tgtDataValid,
  output logic [AD_W-1:0] tgtData,
  output logic [CBE_W-1:0] tgtBeN,
  output logic parityError
);

  // ==========================================================
  // Reset and suspend qualifiers.
  logic clearRegs;
  logic holdRegs;
  logic observe;

  assign clearRegs = reset & ~suspend;
  assign holdRegs = reset & suspend;
  assign observe = ~reset & ~link.devAdOe;

  // ==========================================================
  // Initiator state.
  phase_t phase_reg;
  logic [AD_W-1:0] dataHold_reg;
  logic [CBE_W-1:0] beHold_reg;
  logic [AD_W-1:0] adOut_reg;
  logic [CBE_W-1:0] cbeOut_reg;
  logic busOe_reg;
  logic parOut_reg;
  logic parOe_reg;
  logic addrPhase_reg;
  logic dataPhase_reg;
  logic accept;

  assign initReady = (phase_reg == PH_IDLE) & ~reset;
  assign accept = initValid & initReady;

  // Phase sequencing: address, data, then the trailing parity clock.
  always_ff @(posedge clk) begin
    if (clearRegs) begin
      phase_reg <= PH_IDLE;
    end else if (!holdRegs) begin
      unique case (phase_reg)
        PH_IDLE: begin
          if (accept) begin
            phase_reg <= PH_ADDR;
          end
        end
        PH_ADDR: begin
          phase_reg <= PH_DATA;
        end
        PH_DATA: begin
          phase_reg <= PH_PAR;
        end
        PH_PAR: begin
          phase_reg <= PH_IDLE;
        end
      endcase
    end
  end

  // Data and byte enables wait here while the address is on the bus.
  always_ff @(posedge clk) begin
    if (clearRegs) begin
      dataHold_reg <= AD_RST;
      beHold_reg <= CBE_RST;
    end else if (!holdRegs && accept) begin
      dataHold_reg <= initData;
      beHold_reg <= initBeN;
    end
  end

  // Address/data and command/byte-enable drivers.
  always_ff @(posedge clk) begin
    if (clearRegs) begin
      adOut_reg <= AD_RST;
      cbeOut_reg <= CBE_RST;
      busOe_reg <= 1'b0;
      addrPhase_reg <= 1'b0;
      dataPhase_reg <= 1'b0;
    end else if (!holdRegs) begin
      addrPhase_reg <= accept;
      dataPhase_reg <= (phase_reg == PH_ADDR);
      if (accept) begin
        adOut_reg <= initAddr;
        cbeOut_reg <= initCmd;
        busOe_reg <= 1'b1;
      end else if (phase_reg == PH_ADDR) begin
        adOut_reg <= dataHold_reg;
        cbeOut_reg <= beHold_reg;
      end else if (phase_reg == PH_DATA) begin
        busOe_reg <= 1'b0;
      end
    end
  end

  // Parity follows the phase it covers by exactly one clock.
  always_ff @(posedge clk) begin
    if (clearRegs) begin
      parOut_reg <= PAR_RST;
      parOe_reg <= 1'b0;
    end else if (!holdRegs) begin
      parOe_reg <= busOe_reg;
      parOut_reg <= evenPar(adOut_reg, cbeOut_reg);
    end
  end

  assign link.devAdOut = adOut_reg;
  assign link.devCbeOut = cbeOut_reg;
  assign link.devParOut = parOut_reg;
  assign link.devAdOe = busOe_reg & ~reset;
  assign link.devCbeOe = busOe_reg & ~reset;
  assign link.devParOe = parOe_reg & ~reset;
  assign link.devAddrPhase = addrPhase_reg & ~reset;
  assign link.devDataPhase = dataPhase_reg & ~reset;

  // ==========================================================
  // Target capture.
  always_ff @(posedge clk) begin
    if (reset) begin
      tgtAddrValid <= 1'b0;
      tgtDataValid <= 1'b0;
    end else begin
      tgtAddrValid <= observe & link.addrPhase;
      tgtDataValid <= observe & link.dataPhase;
    end
  end

  always_ff @(posedge clk) begin
    if (clearRegs) begin
      tgtAddr <= AD_RST;
      tgtCmd <= CBE_RST;
      tgtData <= AD_RST;
      tgtBeN <= CBE_RST;
    end else if (!holdRegs) begin
      if (observe && link.addrPhase) begin
        tgtAddr <= link.ad;
        tgtCmd <= link.cbeN;
      end
      if (observe && link.dataPhase) begin
        tgtData <= link.ad & laneMask(link.cbeN);
        tgtBeN <= link.cbeN;
      end
    end
  end

  // ==========================================================
  // Target parity check.
  logic chkPending_reg;
  logic chkPar_reg;
  logic perrDrive_reg;
  logic mismatch;

  assign mismatch = chkPending_reg & (link.par != chkPar_reg);

  always_ff @(posedge clk) begin
    if (clearRegs) begin
      chkPending_reg <= 1'b0;
      chkPar_reg <= PAR_RST;
    end else if (!holdRegs) begin
      chkPending_reg <= observe & (link.addrPhase | link.dataPhase);
      chkPar_reg <= evenPar(link.ad, link.cbeN);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      parityError <= 1'b0;
      perrDrive_reg <= 1'b0;
    end else begin
      parityError <= mismatch;
      perrDrive_reg <= mismatch;
    end
  end

  assign link.devPerrOutN = ~perrDrive_reg;
  assign link.devPerrOe = perrDrive_reg & ~reset;

endmodule : pci_primary_signal_core

`default_nettype wire

// file: pci_primary_signal_core_tb.sv
// Purpose: Self-checking bench joining the device end and the far agent.
// Assumes: Transfers are issued one at a time, never overlapping.
// Notes: Rows of the table are run first, then reset cases.
`timescale 1ns/100ps
`default_nettype none

module pci_primary_signal_core_tb;
  import pci_sig_pkg::*;

  typedef struct packed {
    logic fromHost;
    logic [AD_W-1:0] addr;
    logic [CBE_W-1:0] cmd;
    logic [AD_W-1:0] data;
    logic [CBE_W-1:0] beN;
    logic corrupt;
    logic [1:0] perrs;
  } row_t;

  logic clk, reset, suspend, initValid, reqValid, initReady, reqReady;
  logic tgtAddrValid, tgtDataValid, parityError, perrSeen;
  logic rxAddrValid, rxDataValid;
  logic [AD_W-1:0] tgtAddr, tgtData, rxAddr, rxData, wA, wD;
  logic [CBE_W-1:0] tgtCmd, tgtBeN, wC, wB;
  logic wPa, wPd, prevA, prevD;
  row_t cur;
  row_t rows [5];
  int errorCnt, nTests, nPerr, nHost, nV;

  pci_link_if pci_link_if_i();
  pci_primary_signal_core pci_primary_signal_core_i(.clk(clk),
    .reset(reset), .suspend(suspend), .link(pci_link_if_i.dev),
    .initValid(initValid), .initReady(initReady), .initAddr(cur.addr),
    .initCmd(cur.cmd), .initData(cur.data), .initBeN(cur.beN),
    .tgtAddrValid(tgtAddrValid), .tgtAddr(tgtAddr), .tgtCmd(tgtCmd),
    .tgtDataValid(tgtDataValid), .tgtData(tgtData), .tgtBeN(tgtBeN),
    .parityError(parityError));
  pci_host_agent pci_host_agent_i(.clk(clk), .reset(reset),
    .link(pci_link_if_i.host), .reqValid(reqValid), .reqReady(reqReady),
    .reqAddr(cur.addr), .reqCmd(cur.cmd), .reqData(cur.data),
    .reqBeN(cur.beN), .reqCorrupt(cur.corrupt), .rxAddrValid(rxAddrValid),
    .rxAddr(rxAddr), .rxDataValid(rxDataValid), .rxData(rxData),
    .perrSeen(perrSeen));
  pci_link_monitor pci_link_monitor_i(.clk(clk), .reset(reset),
    .devAdOe(pci_link_if_i.devAdOe), .devCbeOe(pci_link_if_i.devCbeOe),
    .devParOe(pci_link_if_i.devParOe), .devPerrOe(pci_link_if_i.devPerrOe),
    .devAddrPhase(pci_link_if_i.devAddrPhase),
    .devDataPhase(pci_link_if_i.devDataPhase),
    .hostAddrPhase(pci_link_if_i.hostAddrPhase),
    .hostDataPhase(pci_link_if_i.hostDataPhase), .ad(pci_link_if_i.ad),
    .cbeN(pci_link_if_i.cbeN), .par(pci_link_if_i.par),
    .perrN(pci_link_if_i.perrN));

  // ==========================================================
  // Helpers.
  function automatic logic [AD_W-1:0] msk(input logic [CBE_W-1:0] b);
    msk = {{8{~b[3]}}, {8{~b[2]}}, {8{~b[1]}}, {8{~b[0]}}};
  endfunction : msk

  task automatic closeOut();
    if (errorCnt == 0 && nTests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : closeOut

  task automatic chk(input logic ok, input string m);
    nTests++;
    if (ok !== 1'b1) begin
      errorCnt++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk

  // Samples the wire and the pulses at mid-cycle.
  always @(negedge clk) begin
    if (prevA) wPa = pci_link_if_i.par;
    if (prevD) wPd = pci_link_if_i.par;
    prevA = (pci_link_if_i.addrPhase === 1'b1);
    prevD = (pci_link_if_i.dataPhase === 1'b1);
    if (prevA) begin
      wA = pci_link_if_i.ad;
      wC = pci_link_if_i.cbeN;
    end
    if (prevD) begin
      wD = pci_link_if_i.ad;
      wB = pci_link_if_i.cbeN;
    end
    nPerr += (parityError === 1'b1);
    nHost += (perrSeen === 1'b1);
    nV += (tgtAddrValid === 1'b1) + (tgtDataValid === 1'b1);
    nV += (rxAddrValid === 1'b1) + (rxDataValid === 1'b1);
  end

  task automatic xfer(input row_t r);
    int k;
    int v0;
    int p0;
    int h0;
    logic rdy;
    logic [AD_W-1:0] m;
    m = msk(r.beN);
    rdy = 1'b0;
    @(posedge clk);
    cur <= r;
    reqValid <= r.fromHost;
    initValid <= !r.fromHost;
    for (k = 0; k < 20 && rdy !== 1'b1; k++) begin
      @(negedge clk);
      rdy = r.fromHost ? reqReady : initReady;
    end
    if (rdy !== 1'b1) begin
      errorCnt++;
      closeOut();
    end
    p0 = nPerr;
    h0 = nHost;
    v0 = nV;
    @(posedge clk);
    reqValid <= 1'b0;
    initValid <= 1'b0;
    repeat (8) @(negedge clk);
    chk(nV - v0 == 2, "phase pulses");
    chk(wA === r.addr && wC === r.cmd, "address phase wire");
    chk((wD & m) === (r.data & m) && wB === r.beN, "data wire");
    chk(wPa === (^{r.addr, r.cmd} ^ r.corrupt), "address par");
    chk(wPd === (^{r.data, r.beN} ^ r.corrupt), "data par");
    chk(nPerr - p0 == r.perrs && nHost - h0 == r.perrs, "errors");
    if (r.fromHost) begin
      chk(tgtAddr === r.addr && tgtCmd === r.cmd, "target address");
      chk(tgtData === (r.data & m) && tgtBeN === r.beN, "target data");
    end else begin
      chk(rxAddr === r.addr && (rxData & m) === (r.data & m), "rx");
    end
  endtask : xfer

  task automatic doReset(input logic sus);
    @(posedge clk);
    reset <= 1'b1;
    suspend <= sus;
    @(negedge clk);
    chk({pci_link_if_i.devAdOe, pci_link_if_i.devCbeOe, pci_link_if_i.devParOe,
      pci_link_if_i.devPerrOe, initReady} === 5'h00, "float");
    @(posedge clk);
    @(posedge clk);
    reset <= 1'b0;
    suspend <= 1'b0;
    @(negedge clk);
  endtask : doReset

  // ==========================================================
  // Stimulus.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    reset = 1'b1;
    suspend = 1'b0;
    initValid = 1'b0;
    reqValid = 1'b0;
    cur = '0;
    errorCnt = 0;
    nTests = 0;
    rows[0] = '{1'b1, 32'h1234_5678, 4'h7, 32'hdead_beef, 4'h0, 1'b0, 2'h0};
    rows[1] = '{1'b1, 32'h0000_0004, 4'h6, 32'ha5a5_5a5a, 4'h5, 1'b0, 2'h0};
    rows[2] = '{1'b1, 32'hffff_fff0, 4'h3, 32'h0f0f_f0f0, 4'ha, 1'b1, 2'h2};
    rows[3] = '{1'b0, 32'h8000_0000, 4'h7, 32'h0123_4567, 4'he, 1'b0, 2'h0};
    rows[4] = '{1'b0, 32'h0000_00ff, 4'h2, 32'hfedc_ba98, 4'hf, 1'b0, 2'h0};
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      xfer(rows[i]);
    end
    doReset(1'b1);
    chk(tgtAddr === rows[2].addr && tgtBeN === rows[2].beN, "kept");
    doReset(1'b0);
    chk(tgtAddr === AD_RST && tgtBeN === CBE_RST, "cleared");
    chk(initReady === 1'b1, "ready after reset");
    xfer(rows[3]);
    closeOut();
  end
endmodule : pci_primary_signal_core_tb

`default_nettype wire

// file: pci_sig_pkg.sv
// Purpose: Shared constants, types and parity helpers for both bus ends.
// Assumes: One 32-bit multiplexed address/data bus with active-low C/BE.
// Notes: Parity is even over AD and C/BE together.
`default_nettype none

package pci_sig_pkg;

  // ==========================================================
  // Widths and reset values.
  localparam int AD_W = 32;
  localparam int CBE_W = 4;
  localparam int LANE_W = 8;
  localparam logic [AD_W-1:0] AD_RST = 32'h0000_0000;
  localparam logic [CBE_W-1:0] CBE_RST = 4'hf;
  localparam logic PAR_RST = 1'h0;

  // ==========================================================
  // Bus phase driven by an initiator.
  typedef enum {PH_IDLE, PH_ADDR, PH_DATA, PH_PAR} phase_t;

  // ==========================================================
  // Helpers.
  // Even parity bit over the address/data and command/byte-enable lines.
  function automatic logic evenPar(input logic [AD_W-1:0] ad,
                                   input logic [CBE_W-1:0] cbeN);
    evenPar = ^{ad, cbeN};
  endfunction : evenPar

  // Expands active-low byte enables into a mask of valid data bits.
  function automatic logic [AD_W-1:0] laneMask(input logic [CBE_W-1:0] cbeN);
    logic [AD_W-1:0] m;
    m = '0;
    for (int i = 0; i < CBE_W; i++) begin
      m[i*LANE_W +: LANE_W] = {LANE_W{~cbeN[i]}};
    end
    laneMask = m;
  endfunction : laneMask

endpackage : pci_sig_pkg

`default_nettype wire
